// file: hdl/pram_block.sv
/*
 * Large embedded memory block: 4096 rows of sixteen nine-bit lanes,
 * two ports of up to 72 bits, APB configuration and status.
 * Assumes all port inputs are synchronous to sys_clk; each port's
 * clock enable stands for that port's own clock.
 */
`timescale 1ns/1ps

// Contract
// [R1] Array holds 589,824 bits including parity.
// [R2] Modes: true dual, simple dual, single, FIFO.
// [R3] No preload; contents undefined until written.
// [R4] All inputs registered; no asynchronous paths. The port output clear acts asynchronously.
// [R5] Output register per port may be bypassed.
// [R6] Depths 64K to 4K, widths 9 to 144.
// [R7] No 144-bit width in true dual-port.
// [R8] Simple dual: 9-72 free; 144 both sides.
// [R9] True dual: ports 9 to 72 independently.
// [R10] One select: high writes, low reads.
// [R11] Lane written when select and enable high.
// [R12] Byte enables: 2, 4, 8 for 18/36/72.
// [R13] Enable i gates bits 9i+8 down to 9i.
// [R14] 144 wide merges both enables into sixteen.
// [R15] Any enable combination allowed, even none.
// [R16] Eight-bit widths use eight-bit lanes likewise.
// [R17] Port input registers share one clock.
// [R18] Each port has own enable, clear, select.
// [R19] Each port has 72 inputs, 72 outputs.
// [R20] Masked lanes keep their previous value.
// [R21] Port registers follow own enable and clear.
// [R22] Disabled registers hold; no operation launched.
// [R23] Clear zeroes output register, not the array.
module pram_block (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // APB slave.
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Port A.
    input  wire logic        ceA,
    input  wire logic        clrA,
    input  wire logic        wrSelA,
    input  wire logic [7:0]  beA,
    input  wire logic [15:0] addrA,
    input  wire logic [71:0] dinA,
    output logic      [71:0] doutA,
    // Port B.
    input  wire logic        ceB,
    input  wire logic        clrB,
    input  wire logic        wrSelB,
    input  wire logic [7:0]  beB,
    input  wire logic [15:0] addrB,
    input  wire logic [71:0] dinB,
    output logic      [71:0] doutB
);

    // ====
    // Helper functions
    // ====

    // Row that a port address falls in at width code w.
    function automatic logic [11:0] rowOf(input logic [15:0] a, input logic [2:0] w);
        logic [15:0] s;
        s = a >> (pram_pkg::W144 - w);
        return s[11:0];
    endfunction : rowOf

    // First lane within the row that a port address selects.
    function automatic logic [3:0] offOf(input logic [15:0] a, input logic [2:0] w);
        logic [3:0] lo;
        logic [3:0] m;
        m  = 4'((5'h01 << (pram_pkg::W144 - w)) - 5'h01);
        lo = a[3:0] & m;
        return 4'(lo << w);
    endfunction : offOf

    // Lanes of the row written by one port.
    function automatic logic [15:0] laneMask(input logic [2:0] w, input logic [3:0] off,
                                             input logic [15:0] be);
        logic [15:0] r;
        int          idx;
        r = 16'h0;
        for (int l = 0; l < pram_pkg::LANES; l++) begin
            idx = l - int'(off);
            if (idx >= 0 && idx < (1 << w)) begin
                r[l] = be[idx];              // [R11] [R15]
            end
        end
        return r;
    endfunction : laneMask

    // Port data steered into its row lanes; eight-bit lanes get a zero top bit.
    function automatic logic [143:0] laneData(input logic [2:0] w, input logic [3:0] off,
                                              input logic [143:0] d, input logic bm);
        logic [143:0] r;
        int           idx;
        r = 144'h0;
        for (int l = 0; l < pram_pkg::LANES; l++) begin
            idx = l - int'(off);
            if (idx >= 0 && idx < (1 << w)) begin
                if (bm) begin
                    r[pram_pkg::LANE_W*l +: pram_pkg::LANE_W] =
                        {1'b0, d[pram_pkg::BYTE_W*idx +: pram_pkg::BYTE_W]};  // [R16]
                end else begin
                    r[pram_pkg::LANE_W*l +: pram_pkg::LANE_W] =
                        d[pram_pkg::LANE_W*idx +: pram_pkg::LANE_W];          // [R13] [R14]
                end
            end
        end
        return r;
    endfunction : laneData

    // Lanes of a row gathered back into a port word.
    function automatic logic [143:0] readLanes(input logic [143:0] word, input logic [2:0] w,
                                               input logic [3:0] off, input logic bm);
        logic [143:0] r;
        logic [8:0]   lane;
        r    = 144'h0;
        lane = 9'h000;
        for (int i = 0; i < pram_pkg::LANES; i++) begin
            if (i < (1 << w)) begin
                lane = word[pram_pkg::LANE_W*(i + int'(off)) +: pram_pkg::LANE_W];
                if (bm) begin
                    r[pram_pkg::BYTE_W*i +: pram_pkg::BYTE_W] = lane[7:0];
                end else begin
                    r[pram_pkg::LANE_W*i +: pram_pkg::LANE_W] = lane;
                end
            end
        end
        return r;
    endfunction : readLanes

    // Number of words at width code w.
    function automatic logic [16:0] depthOf(input logic [2:0] w);
        return 17'(17'(pram_pkg::ROWS) << (pram_pkg::W144 - w));
    endfunction : depthOf

    // FIFO pointer advance with wrap at the depth.
    function automatic logic [15:0] nextPtr(input logic [15:0] p, input logic [2:0] w);
        logic [16:0] n;
        n = {1'b0, p} + 17'h00001;
        return (n == depthOf(w)) ? 16'h0000 : n[15:0];
    endfunction : nextPtr

    // ====
    // Reset release
    // ====
    logic rstMeta;                           // First stage, read only by rstN.
    logic rstN;                              // Released reset for the block.

    // Assert at once, release after two clock edges.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    // ====
    // APB registers
    // ====
    logic [11:0]     cfg;                    // Configuration register.
    logic [16:0]     count;                  // FIFO fill in words.
    logic            cfgErr;                 // Illegal configuration.
    logic            fifoEmpty;              // FIFO has no words.
    logic            fifoFull;               // FIFO has no room.
    pram_pkg::mode_t mode;                   // Operating mode.
    logic [2:0]      wA;                     // Port A width code.
    logic [2:0]      wB;                     // Port B width code.

    wire        hitCfg  = (paddr == pram_pkg::ADDR_CFG);
    wire        hitStat = (paddr == pram_pkg::ADDR_STAT);
    wire        apbWr   = psel & penable & pwrite & hitCfg;
    wire [31:0] rdMux   = hitCfg  ? {20'h0, cfg} :
                          hitStat ? {11'h0, count, 1'b0, fifoFull, fifoEmpty, cfgErr} :
                          32'h0;

    // The slave never waits; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(hitCfg | hitStat);

    // Configuration write, and read data loaded in the setup cycle.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            cfg    <= pram_pkg::CFG_RESET;
            prdata <= 32'h0;
        end else begin
            if (apbWr) begin
                cfg <= pwdata[pram_pkg::CFG_W-1:0];
            end
            if (psel & ~penable) begin
                prdata <= rdMux;
            end
        end
    end

    // ======================================================================
    // Configuration decode
    // ======================================================================
    assign mode = pram_pkg::mode_t'(cfg[pram_pkg::CFG_MODE_LSB +: 2]);    // [R2]
    assign wA   = cfg[pram_pkg::CFG_WA_LSB +: 3];                        // [R6]
    assign wB   = cfg[pram_pkg::CFG_WB_LSB +: 3];
    wire bmA    = cfg[pram_pkg::CFG_BMA];
    wire bmB    = cfg[pram_pkg::CFG_BMB];
    wire wideA  = (wA == pram_pkg::W144);
    wire wideB  = (wB == pram_pkg::W144);
    wire isTdp  = (mode == pram_pkg::MODE_TDP);
    wire isSdp  = (mode == pram_pkg::MODE_SDP);
    wire isSp   = (mode == pram_pkg::MODE_SP);
    wire isFifo = (mode == pram_pkg::MODE_FIFO);
    // In the wide organisation port A carries the address for both halves; simple dual reads take it from port B.
    wire wide   = wideA & (isSp | isSdp);

    // Width codes above the widest, or pairings the block cannot drive.
    assign cfgErr = (wA > pram_pkg::W144) | (wB > pram_pkg::W144)
                  | (isTdp & (wideA | wideB))                            // [R7] [R9]
                  | (isSdp & (wideA != wideB))                           // [R8]
                  | (isFifo & ((wA != wB) | wideA));

    // ======================================================================
    // Operation launch
    // ======================================================================
    logic [15:0] wrPtr;                      // FIFO write pointer.
    logic [15:0] rdPtr;                      // FIFO read pointer.

    // Select high writes, low reads; a low enable launches nothing.
    wire goWrA = ceA & wrSelA & ~cfgErr & ~(isFifo & fifoFull);          // [R10] [R22]
    wire goRdA = ceA & ~wrSelA & ~cfgErr & (isTdp | isSp);               // [R10]
    wire goWrB = ceB & wrSelB & ~cfgErr & isTdp;                         // [R18]
    wire goRdB = ceB & ~wrSelB & ~cfgErr
               & (isTdp | isSdp | (isFifo & ~fifoEmpty));                // [R22]
    wire push  = goWrA & isFifo;
    wire pop   = goRdB & isFifo;

    // FIFO mode replaces the port addresses by its own pointers.
    wire [15:0] effA = isFifo ? wrPtr : addrA;
    wire [15:0] effB = isFifo ? rdPtr : addrB;

    // Byte enables apply from x18 up; x9 writes on the select alone.
    wire [15:0] beEffA = wide ? {beB, beA} :                             // [R14]
                         (wA == pram_pkg::W9) ? 16'hFFFF : {8'hFF, beA}; // [R12]
    wire [15:0] beEffB = (wB == pram_pkg::W9) ? 16'hFFFF : {8'hFF, beB}; // [R12]

    wire [11:0]  rowA  = rowOf(effA, wA);
    wire [11:0]  rowB  = rowOf(effB, wB);
    wire [15:0]  maskA = laneMask(wA, offOf(effA, wA), beEffA);          // [R11]
    wire [15:0]  maskB = laneMask(wB, offOf(effB, wB), beEffB);          // [R11]
    wire [143:0] datA  = laneData(wA, offOf(effA, wA),
                                  wide ? {dinB, dinA} : {72'h0, dinA}, bmA);
    wire [143:0] datB  = laneData(wB, offOf(effB, wB), {72'h0, dinB}, bmB);

    // ======================================================================
    // Storage array
    // ======================================================================
    // Rows times row width gives the full bit count; no reset, no preload.
    logic [143:0] mem [pram_pkg::ROWS];      // [R1] [R3]

    // Writes are taken on the clock edge; only enabled lanes change, and
    // port B wins a lane that both ports write in the same cycle.
    always_ff @(posedge sys_clk) begin
        for (int l = 0; l < pram_pkg::LANES; l++) begin
            if (goWrA & maskA[l]) begin
                mem[rowA][pram_pkg::LANE_W*l +: pram_pkg::LANE_W] <=
                    datA[pram_pkg::LANE_W*l +: pram_pkg::LANE_W];        // [R4] [R20]
            end
            if (goWrB & maskB[l]) begin
                mem[rowB][pram_pkg::LANE_W*l +: pram_pkg::LANE_W] <=
                    datB[pram_pkg::LANE_W*l +: pram_pkg::LANE_W];        // [R20]
            end
        end
    end

    // ======================================================================
    // Read address registers and FIFO state
    // ======================================================================
    logic [15:0] rdAddrA;                    // Registered port A read address.
    logic [15:0] rdAddrB;                    // Registered port B read address.

    // Read addresses are captured only on a launched read.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rdAddrA <= 16'h0000;
            rdAddrB <= 16'h0000;
        end else begin
            if (goRdA) begin
                rdAddrA <= addrA;            // [R4] [R17] [R21]
            end
            if (goRdB) begin
                rdAddrB <= effB;             // [R17] [R21]
            end
        end
    end

    // Pointers and fill count; a configuration write empties the FIFO.
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr <= 16'h0000;
            rdPtr <= 16'h0000;
            count <= 17'h00000;
        end else if (apbWr) begin
            wrPtr <= 16'h0000;
            rdPtr <= 16'h0000;
            count <= 17'h00000;
        end else begin
            if (push) begin
                wrPtr <= nextPtr(wrPtr, wA);
            end
            if (pop) begin
                rdPtr <= nextPtr(rdPtr, wB);
            end
            if (push & ~pop) begin
                count <= count + 17'h00001;
            end else if (pop & ~push) begin
                count <= count - 17'h00001;
            end
        end
    end

    assign fifoEmpty = (count == 17'h00000);
    assign fifoFull  = (count == depthOf(wA));

    // ======================================================================
    // Read data and output stages
    // ======================================================================
    wire [143:0] rawA = readLanes(mem[rowOf(rdAddrA, wA)], wA, offOf(rdAddrA, wA), bmA);
    wire [143:0] rawB = readLanes(mem[rowOf(rdAddrB, wB)], wB, offOf(rdAddrB, wB), bmB);

    // A 144-bit word splits over both 72-bit outputs, low half on port A.
    wire [71:0] arrA = (wide & isSdp) ? rawB[71:0] : rawA[71:0];         // [R19]
    wire [71:0] arrB = wide ? (isSdp ? rawB[143:72] : rawA[143:72])
                            : rawB[71:0];                                // [R19]

    // Port A output stage with its own enable, clear and bypass.
    pram_out_stage outStageA (
        .clk     (sys_clk),
        .rstN    (rstN),
        .clr     (clrA),
        .ce      (ceA),
        .bypass  (cfg[pram_pkg::CFG_BYPA]),
        .arrData (arrA),
        .dout    (doutA)
    );

    // Port B output stage with its own enable, clear and bypass.
    pram_out_stage outStageB (
        .clk     (sys_clk),
        .rstN    (rstN),
        .clr     (clrB),
        .ce      (ceB),
        .bypass  (cfg[pram_pkg::CFG_BYPB]),
        .arrData (arrB),
        .dout    (doutB)
    );

endmodule : pram_block

// file: pkg/pram_pkg.sv
/*
 * Shared constants for the large dual-port memory block: array geometry,
 * port width codes, operating modes and the APB register map.
 * Assumes every user of it names things as pram_pkg::name.
 */
package pram_pkg;

    // ====
    // Array geometry
    // ====
    localparam int TOTAL_BITS = 589824;      // Storage bits, parity included.
    localparam int ROWS       = 4096;        // Rows of the widest organisation.
    localparam int ROW_W      = 12;          // Row index width.
    localparam int LANES      = 16;          // Nine-bit lanes in one row.
    localparam int LANE_W     = 9;           // Lane width with parity.
    localparam int BYTE_W     = 8;           // Lane width without parity.
    localparam int WORD_W     = 144;         // Row width.
    localparam int ADDR_W     = 16;          // Port address width.
    localparam int DATA_W     = 72;          // Port data width.
    localparam int BE_W       = 8;           // Byte enables per port.
    localparam int CNT_W      = 17;          // FIFO fill counter width.

    // ====
    // Port width codes: lanes per word is two to the power of the code
    // ====
    localparam logic [2:0] W9   = 3'h0;
    localparam logic [2:0] W18  = 3'h1;
    localparam logic [2:0] W36  = 3'h2;
    localparam logic [2:0] W72  = 3'h3;
    localparam logic [2:0] W144 = 3'h4;

    // Operating modes, Gray coded.
    typedef enum logic [1:0] {
        MODE_TDP  = 2'h0,
        MODE_SDP  = 2'h1,
        MODE_SP   = 2'h3,
        MODE_FIFO = 2'h2
    } mode_t;

    // ====
    // APB register map
    // ====
    localparam int          APB_ADDR_W = 12;
    localparam logic [11:0] ADDR_CFG   = 12'h000;
    localparam logic [11:0] ADDR_STAT  = 12'h004;
    localparam int          CFG_W      = 12;
    localparam logic [11:0] CFG_RESET  = 12'h000;
    localparam int CFG_MODE_LSB = 0;         // Two bits of mode.
    localparam int CFG_WA_LSB   = 2;         // Three bits of port A width.
    localparam int CFG_WB_LSB   = 5;         // Three bits of port B width.
    localparam int CFG_BYPA     = 8;         // Port A output register bypass.
    localparam int CFG_BYPB     = 9;         // Port B output register bypass.
    localparam int CFG_BMA      = 10;        // Port A eight-bit lanes.
    localparam int CFG_BMB      = 11;        // Port B eight-bit lanes.
    localparam int STAT_ERR     = 0;         // Illegal configuration.
    localparam int STAT_EMPTY   = 1;         // FIFO empty.
    localparam int STAT_FULL    = 2;         // FIFO full.
    localparam int STAT_CNT_LSB = 4;         // FIFO fill count.

endpackage : pram_pkg

// file: hdl/pram_out_stage.sv
/*
 * Read-data output stage of one memory port: a register with clock
 * enable and clear, and a bypass that shows the array data directly.
 * Assumes the array data is already a registered-address read.
 */
`timescale 1ns/1ps

module pram_out_stage (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstN,
    // Port controls.
    input  wire logic        clr,
    input  wire logic        ce,
    input  wire logic        bypass,
    // Data.
    input  wire logic [71:0] arrData,
    output logic      [71:0] dout
);

    // ====
    // Output register
    // ====
    logic [71:0] q;                          // Registered read data.

    // The clear acts at once and leaves the array alone.
    always_ff @(posedge clk or negedge rstN or posedge clr) begin
        if (!rstN) begin
            q <= 72'h0;
        end else if (clr) begin
            q <= 72'h0;                      // [R23]
        end else if (ce) begin
            q <= arrData;                    // [R22]
        end
    end

    // Bypass selects the array data, else the register.
    assign dout = bypass ? arrData : q;      // [R5]

endmodule : pram_out_stage

// file: tb/pram_block_sva.sv
/* Checker for pram_block: APB answers, output clear and output hold.
   Assumes it is bound to pram_block and sees only that module's ports. */
`timescale 1ns/1ps

module pram_block_chk (
    // Clock, reset and APB.
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Memory ports.
    input wire logic        ceA,
    input wire logic        clrA,
    input wire logic [71:0] doutA,
    input wire logic        ceB,
    input wire logic        clrB,
    input wire logic [71:0] doutB
);
    // ====
    // Configuration shadow
    logic [11:0] cfg;  // Last configuration word written.
    wire logic cfgWr  = psel && penable && pwrite && paddr == pram_pkg::ADDR_CFG;
    wire logic mapped = paddr == pram_pkg::ADDR_CFG || paddr == pram_pkg::ADDR_STAT;
    // Follows completed writes, so the bypass settings are known.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) cfg <= pram_pkg::CFG_RESET;
        else if (cfgWr) cfg <= pwdata[11:0];
    end
    // ====
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Setup phase of a configuration read, then its access phase.
    sequence cfgRead;
        psel && !penable && !pwrite && paddr == pram_pkg::ADDR_CFG ##1 psel && penable;
    endsequence
    // Setup phase to an unmapped address, then its access phase.
    sequence badAccess;
        psel && !penable && !mapped ##1 psel && penable;
    endsequence
    pready_high_a: assert property (pready == 1'b1)
        else $error("pready low");
    slverr_map_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    slverr_idle_a: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    cfg_readback_a: assert property (cfgRead |-> prdata == 32'(cfg))
        else $error("configuration read back wrong");
    unmapped_zero_a: assert property (badAccess |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    clra_zero_a: assert property (clrA && !cfg[8] |-> doutA == 72'h0)
        else $error("port A clear ignored");
    clrb_zero_a: assert property (clrB && !cfg[9] |-> doutB == 72'h0)
        else $error("port B clear ignored");
    holda_stable_a: assert property (!ceA && !clrA && !cfgWr && !cfg[8]
        |=> $stable(doutA) || clrA)
        else $error("port A output moved while disabled");
    holdb_stable_a: assert property (!ceB && !clrB && !cfgWr && !cfg[9]
        |=> $stable(doutB) || clrB)
        else $error("port B output moved while disabled");
endmodule : pram_block_chk

bind pram_block pram_block_chk u_chk (.*);

// file: tb/fabric_port.sv
/* Fabric user logic on one memory port: writes, reads and clear pulses.
   Assumes a free-running clock shared with the block. */
`timescale 1ns/1ps

module fabric_port (
    // Clock.
    input  wire logic        clk,
    // Port controls and data, driven after rising edges.
    output logic             ce    = 1'b0,
    output logic             clr   = 1'b0,
    output logic             wrSel = 1'b0,
    output logic      [7:0]  be    = 8'hFF,
    output logic      [15:0] addr  = 16'h0000,
    output logic      [71:0] din   = 72'h0,
    input  wire logic [71:0] dout
);
    // One operation; reads keep ce a second edge so the register loads.
    task automatic op(input logic en, input logic w, input logic [15:0] a,
                      input logic [7:0] b, input logic [71:0] d, output logic [71:0] q);
        @(posedge clk);
        ce <= en;
        wrSel <= w;
        addr <= a;
        be <= b;
        din <= d;
        if (!w) @(posedge clk);
        @(posedge clk);
        ce <= 1'b0;
        wrSel <= 1'b0;
        din <= ~d; // Released data shows the inverse, never a stale copy.
        @(negedge clk);
        q = dout;
    endtask : op
    // Pulses the clear for one cycle and samples the output meanwhile.
    task automatic clear(output logic [71:0] q);
        @(posedge clk);
        clr <= 1'b1;
        @(negedge clk);
        q = dout;
        @(posedge clk);
        clr <= 1'b0;
    endtask : clear
endmodule : fabric_port

// file: tb/tb_pram_block.sv
/* Bench for pram_block: configuration checks, masked writes, mixed
   widths, clock enable and clear. Assumes fabric_port on both ports. */
`timescale 1ns/1ps

module tb_pram_block;
    // ====
    // Signals
    logic        sys_clk = 1'b0;   // 10 MHz clock.
    logic        arst_n  = 1'b0;   // Reset, active low.
    logic [11:0] paddr   = 12'h000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    wire logic [31:0] prdata;
    wire logic        pready, pslverr, ceA, clrA, wrSelA, ceB, clrB, wrSelB;
    wire logic [7:0]  beA, beB;
    wire logic [15:0] addrA, addrB;
    wire logic [71:0] dinA, dinB, doutA, doutB;
    int          err_total = 0;    // Mismatches.
    int          n_checks = 0;     // Comparisons.
    logic [31:0] q;                // APB read data.
    logic        e;                // APB error flag.
    logic [71:0] r;                // Port read data.
    logic [32:0] cfgCase [4] = '{{1'b1, 32'h010}, {1'b1, 32'h011},
                                 {1'b0, 32'h091}, {1'b0, 32'h324}};
    localparam logic [71:0] D1 = 72'hABC_0002_B5C3;
    localparam logic [71:0] D2 = 72'h123_0000_F0F1;
    localparam logic [71:0] D3 = 72'h777_0009_ABCD_1234;
    always #50 sys_clk = ~sys_clk;
    pram_block uut (.*);
    fabric_port pA (.clk(sys_clk), .ce(ceA), .clr(clrA), .wrSel(wrSelA), .be(beA),
        .addr(addrA), .din(dinA), .dout(doutA));
    fabric_port pB (.clk(sys_clk), .ce(ceB), .clr(clrB), .wrSel(wrSelB), .be(beB),
        .addr(addrB), .din(dinB), .dout(doutB));
    // ====
    // Tasks
    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    // Compares one value with its expectation.
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask : chk
    // One APB transfer; waits for pready under a bound.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask : apb
    // ====
    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        apb(1'b0, pram_pkg::ADDR_CFG, 32'h0, q, e);
        chk(72'(q), 72'(pram_pkg::CFG_RESET));
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk(72'({e, q}), 72'({1'b1, 32'h0}));
        // Four organisations are tried; only the two illegal ones raise the flag.
        foreach (cfgCase[i]) begin
            apb(1'b1, pram_pkg::ADDR_CFG, cfgCase[i][31:0], q, e);
            apb(1'b0, pram_pkg::ADDR_STAT, 32'h0, q, e);
            chk(72'(q[0]), 72'(cfgCase[i][32]));
        end
        $display("test configuration done");
        // Both ports 18 bits, bypassed: full, masked, empty and disabled writes.
        pA.op(1'b1, 1'b1, 16'h0005, 8'hFF, D1, r);
        pA.op(1'b1, 1'b1, 16'h0005, 8'h01, D2, r);
        pA.op(1'b1, 1'b1, 16'h0005, 8'h00, 72'h3FFFF, r);
        pA.op(1'b0, 1'b1, 16'h0005, 8'hFF, 72'h0, r);
        pB.op(1'b1, 1'b0, 16'h0005, 8'hFF, 72'h0, r);
        chk(72'(r[17:0]), 72'({D1[17:9], D2[8:0]}));
        $display("test byte enables done");
        // Port B at 36 bits writes two 18-bit words of port A.
        apb(1'b1, pram_pkg::ADDR_CFG, 32'h344, q, e);
        pB.op(1'b1, 1'b1, 16'h0003, 8'hFF, D3, r);
        pA.op(1'b1, 1'b0, 16'h0006, 8'hFF, 72'h0, r);
        chk(72'(r[17:0]), 72'(D3[17:0]));
        pA.op(1'b1, 1'b0, 16'h0005, 8'hFF, 72'h0, r);
        chk(72'(r[17:0]), 72'({D1[17:9], D2[8:0]}));
        $display("test mixed widths done");
        // Port A registered: read, clear, read again.
        apb(1'b1, pram_pkg::ADDR_CFG, 32'h244, q, e);
        pA.op(1'b1, 1'b0, 16'h0007, 8'hFF, 72'h0, r);
        chk(72'(r[17:0]), 72'(D3[35:18]));
        pA.clear(r);
        chk(r, 72'h0);
        pA.op(1'b1, 1'b0, 16'h0007, 8'hFF, 72'h0, r);
        chk(72'(r[17:0]), 72'(D3[35:18]));
        $display("test clear done");
        close_out();
    end
endmodule : tb_pram_block
